// *** icb_pkg.sv ***
// Package for the interrupt read-clear bank
// What this block does
// - Receive-overrun clear read clears raw bit 1
// - Transmit-overrun clear read clears raw bit 3
// - Read-request clear read clears raw bit 5
// - Abort clear read clears bit 6, source record
// - Abort clear read releases flushed transmit FIFO
// - Source bit 9 exception honoured on clear
// - Receive-done clear read clears raw bit 7
// - Activity clear only when controller idle
// - Hardware clears activity when disabled, idle
// - Activity clear read returns activity flag
// - Overrun on full 32-entry buffer plus byte
package icb_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [31:0] ICB_ADDR_RX_OVER  = 32'h5000_1348;
    localparam logic [31:0] ICB_ADDR_TX_OVER  = 32'h5000_134c;
    localparam logic [31:0] ICB_ADDR_RD_REQ   = 32'h5000_1350;
    localparam logic [31:0] ICB_ADDR_TRANSMIT_ABORT_FLAG  = 32'h5000_1354;
    localparam logic [31:0] ICB_ADDR_RX_DONE  = 32'h5000_1358;
    localparam logic [31:0] ICB_ADDR_ACTIVITY = 32'h5000_135c;
    localparam logic [31:0] ICB_ADDR_STOP     = 32'h5000_1360;
    localparam logic [31:0] ICB_ADDR_RAW      = 32'h5000_1380;
    localparam logic [31:0] ICB_ADDR_MASK     = 32'h5000_1384;
    localparam logic [31:0] ICB_ADDR_SOURCE   = 32'h5000_1388;
    localparam logic [31:0] ICB_ADDR_CTRL     = 32'h5000_138c;
    // ------------------------------------------------------------------
    // Raw status bit positions, widths, depth, reset value and response codes
    // ------------------------------------------------------------------
    localparam int ICB_B_RX_OVER  = 1;
    localparam int ICB_B_TX_OVER  = 3;
    localparam int ICB_B_RD_REQ   = 5;
    localparam int ICB_B_TRANSMIT_ABORT_FLAG  = 6;
    localparam int ICB_B_RX_DONE  = 7;
    localparam int ICB_B_ACTIVITY = 8;
    localparam int ICB_B_STOP     = 9;
    localparam int ICB_RAW_W      = 16;
    localparam int ICB_SRC_W      = 16;
    localparam int ICB_SRC_KEEP   = 9;
    localparam int ICB_RX_DEPTH   = 32;
    localparam logic [15:0] ICB_RAW_RESET = 16'h0000;
    localparam logic [1:0]  ICB_RESP_OKAY   = 2'b00;
    localparam logic [1:0]  ICB_RESP_DECERR = 2'b11;
endpackage

// *** icb_read_clear_bank.sv ***
// Interrupt raw status bank with read-to-clear registers over AXI4-Lite
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module icb_read_clear_bank #(
    parameter int RX_DEPTH = icb_pkg::ICB_RX_DEPTH
) (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic        s_awvalid,
    output logic             s_awready,
    input  wire logic [31:0] s_awaddr,
    // AXI4-Lite write data
    input  wire logic        s_wvalid,
    output logic             s_wready,
    input  wire logic [31:0] s_wdata,
    input  wire logic [3:0]  s_wstrb,
    // AXI4-Lite write response
    output logic             s_bvalid,
    input  wire logic        s_bready,
    output logic [1:0]       s_bresp,
    // AXI4-Lite read address
    input  wire logic        s_arvalid,
    output logic             s_arready,
    input  wire logic [31:0] s_araddr,
    // AXI4-Lite read data
    output logic             s_rvalid,
    input  wire logic        s_rready,
    output logic [31:0]      s_rdata,
    output logic [1:0]       s_rresp,
    // Controller events, one-cycle pulses, with receive level and abort reason
    input  wire logic        ev_tx_over,
    input  wire logic        ev_rd_req,
    input  wire logic        ev_rx_done,
    input  wire logic        ev_stop,
    input  wire logic        ev_activity,
    input  wire logic        rx_byte_in,
    input  wire logic [5:0]  rx_level,
    input  wire logic        abort_pulse,
    input  wire logic [15:0] abort_reason,
    // Controller state
    input  wire logic        ctrl_active,
    // Outputs
    output logic             tx_fifo_flushed,
    output logic             ctrl_enable,
    output logic             irq
);
    import icb_pkg::*;

    logic [15:0] raw_interrupt_status;
    logic [15:0] mask;
    logic [15:0] abort_source_record;
    logic        aw_held;
    logic        w_held;
    logic [31:0] aw_addr;
    logic [31:0] w_data;

    // ------------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------------
    wire aw_take = s_awvalid && s_awready;
    wire w_take  = s_wvalid && s_wready;
    wire aw_now  = aw_held || aw_take;
    wire w_now   = w_held || w_take;
    wire [31:0] wa = aw_held ? aw_addr : s_awaddr;
    wire [31:0] wd = w_held ? w_data : s_wdata;
    wire        wr_do = aw_now && w_now && !s_bvalid;
    wire        wr_mask = wr_do && wa == ICB_ADDR_MASK;
    wire        wr_ctrl = wr_do && wa == ICB_ADDR_CTRL;
    wire        wr_ok = wa == ICB_ADDR_MASK || wa == ICB_ADDR_CTRL ||
                        wa == ICB_ADDR_RAW;
    wire        wr_raw = wr_do && wa == ICB_ADDR_RAW && s_wstrb[0];
    assign s_awready = !aw_held && !s_bvalid;
    assign s_wready  = !w_held && !s_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 32'h0000_0000;
            w_data  <= 32'h0000_0000;
            s_bvalid <= 1'b0;
            s_bresp  <= ICB_RESP_OKAY;
        end else begin
            if (wr_do) begin
                aw_held  <= 1'b0;
                w_held   <= 1'b0;
                s_bvalid <= 1'b1;
                s_bresp  <= wr_ok ? ICB_RESP_OKAY : ICB_RESP_DECERR;
            end else begin
                if (aw_take) begin
                    aw_held <= 1'b1;
                    aw_addr <= s_awaddr;
                end
                if (w_take) begin
                    w_held <= 1'b1;
                    w_data <= s_wdata;
                end
                if (s_bvalid && s_bready) begin
                    s_bvalid <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask        <= 16'h0000;
            ctrl_enable <= 1'b0;
        end else begin
            if (wr_mask && s_wstrb[0]) begin
                mask[7:0] <= wd[7:0];
            end
            if (wr_mask && s_wstrb[1]) begin
                mask[15:8] <= wd[15:8];
            end
            if (wr_ctrl && s_wstrb[0]) begin
                ctrl_enable <= wd[0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Read channel and clear decode
    // ------------------------------------------------------------------
    wire rd_do = s_arvalid && s_arready;
    assign s_arready = !s_rvalid;
    wire rd_rx_over = rd_do && s_araddr == ICB_ADDR_RX_OVER;
    wire rd_tx_over = rd_do && s_araddr == ICB_ADDR_TX_OVER;
    wire rd_rd_req  = rd_do && s_araddr == ICB_ADDR_RD_REQ;
    wire rd_abort   = rd_do && s_araddr == ICB_ADDR_TRANSMIT_ABORT_FLAG;
    wire rd_rx_done = rd_do && s_araddr == ICB_ADDR_RX_DONE;
    wire rd_act     = rd_do && s_araddr == ICB_ADDR_ACTIVITY;
    wire rd_stop    = rd_do && s_araddr == ICB_ADDR_STOP;
    wire rd_raw     = s_araddr == ICB_ADDR_RAW;
    wire rd_msk     = s_araddr == ICB_ADDR_MASK;
    wire rd_src     = s_araddr == ICB_ADDR_SOURCE;
    wire rd_ctl     = s_araddr == ICB_ADDR_CTRL;
    wire rd_clr_any = rd_rx_over || rd_tx_over || rd_rd_req || rd_abort ||
                      rd_rx_done || rd_act || rd_stop;
    wire rd_ok = rd_clr_any || rd_raw || rd_msk || rd_src || rd_ctl;

    // Flag returned in bit 0, upper bits zero; value taken before clear
    wire clr_bit =
        (rd_rx_over && raw_interrupt_status[ICB_B_RX_OVER])  ||
        (rd_tx_over && raw_interrupt_status[ICB_B_TX_OVER])  ||
        (rd_rd_req  && raw_interrupt_status[ICB_B_RD_REQ])   ||
        (rd_abort   && raw_interrupt_status[ICB_B_TRANSMIT_ABORT_FLAG])  ||
        (rd_rx_done && raw_interrupt_status[ICB_B_RX_DONE])  ||
        (rd_act     && raw_interrupt_status[ICB_B_ACTIVITY]) ||
        (rd_stop    && raw_interrupt_status[ICB_B_STOP]);
    wire [31:0] rd_value =
        rd_clr_any ? {31'h0000_0000, clr_bit} :
        rd_raw ? {16'h0000, raw_interrupt_status} :
        rd_msk ? {16'h0000, mask} :
        rd_src ? {16'h0000, abort_source_record} :
        rd_ctl ? {31'h0000_0000, ctrl_enable} : 32'h0000_0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_rvalid <= 1'b0;
            s_rdata  <= 32'h0000_0000;
            s_rresp  <= ICB_RESP_OKAY;
        end else if (rd_do) begin
            s_rvalid <= 1'b1;
            s_rdata  <= rd_value;
            s_rresp  <= rd_ok ? ICB_RESP_OKAY : ICB_RESP_DECERR;
        end else if (s_rready) begin
            s_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Raw status flags: set wins over clear
    // ------------------------------------------------------------------
    // Overrun: buffer already holds RX_DEPTH bytes when one more lands
    wire ev_rx_over = rx_byte_in && rx_level == 6'(RX_DEPTH);
    wire act_clear = (rd_act && !ctrl_active) ||
                     (!ctrl_enable && !ctrl_active);
    logic [15:0] set_v;
    logic [15:0] clr_v;
    always_comb begin
        set_v = 16'h0000;
        clr_v = 16'h0000;
        set_v[ICB_B_RX_OVER]  = ev_rx_over;
        set_v[ICB_B_TX_OVER]  = ev_tx_over;
        set_v[ICB_B_RD_REQ]   = ev_rd_req;
        set_v[ICB_B_TRANSMIT_ABORT_FLAG]  = abort_pulse;
        set_v[ICB_B_RX_DONE]  = ev_rx_done;
        set_v[ICB_B_ACTIVITY] = ev_activity;
        set_v[ICB_B_STOP]     = ev_stop;
        clr_v[ICB_B_RX_OVER]  = rd_rx_over;
        clr_v[ICB_B_TX_OVER]  = rd_tx_over;
        clr_v[ICB_B_RD_REQ]   = rd_rd_req;
        clr_v[ICB_B_TRANSMIT_ABORT_FLAG]  = rd_abort;
        clr_v[ICB_B_RX_DONE]  = rd_rx_done;
        clr_v[ICB_B_ACTIVITY] = act_clear;
        clr_v[ICB_B_STOP]     = rd_stop;
    end
    wire [15:0] sw_clr = wr_raw ? {8'h00, wd[7:0]} : 16'h0000;

    // ------------------------------------------------------------------
    // Per-bit flag storage
    // ------------------------------------------------------------------
    // Each flag resolves its own set and clear; the set wins so that an
    // event landing in the same cycle as a clearing read is never lost.
    // Software sees it on the next read instead of missing it for good.
    for (genvar b = 0; b < ICB_RAW_W; b++) begin : g_flag
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                raw_interrupt_status[b] <= ICB_RAW_RESET[b];
            end else if (set_v[b]) begin
                raw_interrupt_status[b] <= 1'b1;
            end else if (clr_v[b] || sw_clr[b]) begin
                raw_interrupt_status[b] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Abort source record and transmit FIFO hold
    // ------------------------------------------------------------------
    // Bit 9 survives the abort clear read; once set, only reset clears it
    wire [15:0] src_keep = 16'(1) << ICB_SRC_KEEP;
    wire [15:0] src_clr = rd_abort ? ~src_keep : 16'h0000;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            abort_source_record <= 16'h0000;
            tx_fifo_flushed     <= 1'b0;
        end else begin
            abort_source_record <= (abort_source_record & ~src_clr) |
                                   (abort_pulse ? abort_reason : 16'h0000);
            if (abort_pulse) begin
                tx_fifo_flushed <= 1'b1;
            end else if (rd_abort) begin
                tx_fifo_flushed <= 1'b0;
            end
        end
    end

    assign irq = |(raw_interrupt_status & mask);
endmodule

// *** icb_read_clear_bank_monitor.sv ***
// Protocol and side-effect checker for the read-clear bank
`timescale 1ns/1ps
module icb_monitor
    import icb_pkg::*;
#(
    parameter int RX_DEPTH = 32
) (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Bus handshakes
    input wire logic        s_arvalid,
    input wire logic        s_arready,
    input wire logic [31:0] s_araddr,
    input wire logic        s_rvalid,
    input wire logic        s_rready,
    input wire logic [31:0] s_rdata,
    input wire logic [1:0]  s_rresp,
    input wire logic        s_bvalid,
    input wire logic        s_bready,
    // Controller side
    input wire logic        rx_byte_in,
    input wire logic [5:0]  rx_level,
    input wire logic        abort_pulse,
    input wire logic        tx_fifo_flushed
);
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_ar_gated: assert property (s_rvalid |-> !s_arready)
        else $error("read address accepted while data pending");
    a_read_answer: assert property (s_arvalid && s_arready |=> s_rvalid)
        else $error("read data not returned next cycle");
    a_read_hold: assert property (s_rvalid && !s_rready
        |=> s_rvalid && $stable(s_rdata)) else $error("read data dropped");
    a_write_hold: assert property (s_bvalid && !s_bready |=> s_bvalid)
        else $error("write response dropped");
    a_decerr_zero: assert property (s_rvalid && s_rresp == ICB_RESP_DECERR
        |-> s_rdata == 32'h0) else $error("error read returns data");
    a_abort_flush: assert property (abort_pulse |=> tx_fifo_flushed)
        else $error("abort did not flush transmit fifo");
    // Only an abort-clear read may release the flush; a reset edge is masked
    a_flush_release: assert property ($fell(tx_fifo_flushed) && $past(aresetn)
        |-> $past(s_arvalid && s_arready && s_araddr == ICB_ADDR_TRANSMIT_ABORT_FLAG))
        else $error("flush released without abort clear read");
    a_clear_upper: assert property (s_arvalid && s_arready && s_araddr inside
        {[ICB_ADDR_RX_OVER:ICB_ADDR_STOP]} |=> s_rdata[31:1] == 31'h0)
        else $error("clear register upper bits not zero");
    cover property (rx_byte_in && rx_level == RX_DEPTH);
    cover property ($fell(tx_fifo_flushed));
    cover property (s_bvalid && s_bready);
endmodule
bind icb_read_clear_bank icb_monitor #(.RX_DEPTH(RX_DEPTH)) icb_monitor_inst (
    .aclk, .aresetn, .s_arvalid, .s_arready, .s_araddr, .s_rvalid, .s_rready,
    .s_rdata, .s_rresp, .s_bvalid, .s_bready, .rx_byte_in, .rx_level,
    .abort_pulse, .tx_fifo_flushed);

// *** icb_read_clear_bank_tb_top.sv ***
// Self-checking bench for the read-clear bank
`timescale 1ns/1ps
module icb_read_clear_bank_tb_top;
    import icb_pkg::*;
    // ------------------------------------------------------------------
    // Stimulus and checks
    // ------------------------------------------------------------------
    logic        aclk = 1'b0, aresetn = 1'b0, ctrl_active = 1'b0;
    logic        s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
    logic        s_arvalid = 1'b0, s_rready = 1'b0;
    logic [31:0] s_awaddr = 32'h0, s_wdata = 32'h0, s_araddr = 32'h0;
    logic [3:0]  s_wstrb = 4'hf;
    logic [6:0]  evs = 7'h0;
    logic [5:0]  rx_level = 6'h0;
    logic [15:0] abort_reason = 16'h0;
    logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic        tx_fifo_flushed, ctrl_enable, irq;
    logic [1:0]  s_bresp, s_rresp, r;
    logic [31:0] s_rdata, d;
    int          fails = 0, samples_checked = 0, cyc = 0;
    logic [31:0] fa [5] = '{ICB_ADDR_RX_OVER, ICB_ADDR_TX_OVER,
        ICB_ADDR_RD_REQ, ICB_ADDR_RX_DONE, ICB_ADDR_STOP};
    int          fb [5] = '{1, 3, 5, 7, 9};
    logic [6:0]  fm [5] = '{7'h20, 7'h01, 7'h02, 7'h04, 7'h08};

    always #10 aclk = ~aclk;

    icb_read_clear_bank icb_read_clear_bank_inst (
        .aclk, .aresetn, .s_awvalid, .s_awready, .s_awaddr, .s_wvalid,
        .s_wready, .s_wdata, .s_wstrb, .s_bvalid, .s_bready, .s_bresp,
        .s_arvalid, .s_arready, .s_araddr, .s_rvalid, .s_rready, .s_rdata,
        .s_rresp, .ev_tx_over(evs[0]), .ev_rd_req(evs[1]),
        .ev_rx_done(evs[2]), .ev_stop(evs[3]), .ev_activity(evs[4]),
        .rx_byte_in(evs[5]), .rx_level, .abort_pulse(evs[6]),
        .abort_reason, .ctrl_active, .tx_fifo_flushed, .ctrl_enable, .irq);

    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] s,
                       input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            $display("wrong value %s expected %h seen %h", n, e, s);
            fails++;
        end
    endtask

    // Ready is looked at mid-cycle, where it is settled; each channel is
    // released just after the rising edge that took it
    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        logic aw_p;
        logic w_p;
        logic aw_g;
        logic w_g;
        logic b_g;
        aw_p = 1'b1;
        w_p  = 1'b1;
        b_g  = 1'b0;
        @(posedge aclk);
        s_awvalid <= 1'b1;
        s_awaddr  <= a;
        s_wvalid  <= 1'b1;
        s_wdata   <= v;
        s_bready  <= 1'b1;
        while (aw_p || w_p) begin
            @(negedge aclk);
            aw_g = aw_p && (s_awready === 1'b1);
            w_g  = w_p && (s_wready === 1'b1);
            @(posedge aclk);
            if (aw_g) begin
                s_awvalid <= 1'b0;
                aw_p = 1'b0;
            end
            if (w_g) begin
                s_wvalid <= 1'b0;
                w_p = 1'b0;
            end
        end
        while (!b_g) begin
            @(negedge aclk);
            b_g = (s_bvalid === 1'b1);
            r   = s_bresp;
            @(posedge aclk);
        end
        s_bready <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] a);
        logic a_p;
        logic a_g;
        logic r_g;
        a_p = 1'b1;
        r_g = 1'b0;
        @(posedge aclk);
        s_arvalid <= 1'b1;
        s_araddr  <= a;
        s_rready  <= 1'b1;
        while (!r_g) begin
            @(negedge aclk);
            a_g = a_p && (s_arready === 1'b1);
            r_g = (s_rvalid === 1'b1);
            d   = s_rdata;
            r   = s_rresp;
            @(posedge aclk);
            if (a_g) begin
                s_arvalid <= 1'b0;
                a_p = 1'b0;
            end
        end
        s_rready <= 1'b0;
    endtask

    task automatic rdc(input string n, input logic [31:0] a,
                       input logic [31:0] e);
        rd(a);
        chk(n, d, e);
    endtask

    task automatic fire(input logic [6:0] m);
        @(posedge aclk);
        evs <= m;
        @(posedge aclk);
        evs <= 7'h0;
    endtask

    always @(posedge aclk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            final_report();
        end
    end

    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            rdc("clear reset", ICB_ADDR_RX_OVER + 32'(4 * i), 32'h0);
        end
        rx_level <= 6'd31;
        fire(7'h20);
        rdc("no overrun", ICB_ADDR_RAW, 32'h0);
        rx_level <= 6'd32;
        for (int k = 0; k < 5; k++) begin
            fire(fm[k]);
            rdc("raw set", ICB_ADDR_RAW, 32'h1 << fb[k]);
            rdc("clear read", fa[k], 32'h1);
            rdc("clear again", fa[k], 32'h0);
            rdc("raw cleared", ICB_ADDR_RAW, 32'h0);
        end
        wr(ICB_ADDR_MASK, 32'h8);
        fire(7'h01);
        @(negedge aclk);
        chk("irq on", irq, 32'h1);
        wr(ICB_ADDR_MASK, 32'h0);
        @(negedge aclk);
        chk("irq masked", irq, 32'h0);
        wr(ICB_ADDR_MASK, 32'h8);
        rd(ICB_ADDR_TX_OVER);
        @(negedge aclk);
        chk("irq cleared", irq, 32'h0);
        abort_reason <= 16'h0201;
        fire(7'h40);
        @(negedge aclk);
        chk("flushed", tx_fifo_flushed, 32'h1);
        rdc("source", ICB_ADDR_SOURCE, 32'h0201);
        rdc("abort clear", ICB_ADDR_TRANSMIT_ABORT_FLAG, 32'h1);
        rdc("source kept", ICB_ADDR_SOURCE, 32'h0200);
        rdc("raw abort", ICB_ADDR_RAW, 32'h0);
        chk("released", tx_fifo_flushed, 32'h0);
        wr(ICB_ADDR_CTRL, 32'h1);
        ctrl_active <= 1'b1;
        fire(7'h10);
        rdc("act busy", ICB_ADDR_ACTIVITY, 32'h1);
        rdc("act held", ICB_ADDR_ACTIVITY, 32'h1);
        ctrl_active <= 1'b0;
        rdc("act idle", ICB_ADDR_ACTIVITY, 32'h1);
        rdc("act gone", ICB_ADDR_ACTIVITY, 32'h0);
        ctrl_active <= 1'b1;
        fire(7'h10);
        wr(ICB_ADDR_CTRL, 32'h0);
        chk("enable off", ctrl_enable, 32'h0);
        rdc("act kept", ICB_ADDR_RAW, 32'h100);
        ctrl_active <= 1'b0;
        rdc("act hw clear", ICB_ADDR_RAW, 32'h0);
        rd(32'h5000_1300);
        chk("bad read resp", r, ICB_RESP_DECERR);
        chk("bad read data", d, 32'h0);
        wr(32'h5000_1300, 32'h1);
        chk("bad write resp", r, ICB_RESP_DECERR);
        final_report();
    end
endmodule
